// [verilog/lultm_top.sv]
// lultm_top: per-channel loopback, all-ones, monitoring and driver tristate control, four channels.
// assumes pins arrive asynchronous, analog line parts are digitised outside, wishbone is on clk_i.
//
// Overview of operation
// (RULE1) three loopbacks: loop pins in hardware mode, control registers in software mode
// (RULE2) analog loopback feeds own transmit line into own receiver, output recovered data
// (RULE3) external receive line is ignored while analog loopback is on
// (RULE4) digital loopback copies transmit clock and rails to receive outputs
// (RULE5) digital loopback still transmits the supplied data on the line
// (RULE6) external receive line is ignored while digital loopback is on
// (RULE7) remote loopback retransmits recovered clock and rails on the line
// (RULE8) system transmit inputs are ignored during remote loopback
// (RULE9) hardware mode: transmit clock high over 16 master clocks gives all ones
// (RULE10) software mode: all-ones register bit sends all ones on that channel
// (RULE11) auto all-ones bit inserts all ones on that channel when signal is lost
// (RULE12) all-ones timed by master clock, unavailable when master clock is not toggling
// (RULE13) digital loopback disabled while all ones is active on the channel
// (RULE14) channel 0 monitors another channel's line input or output without disturbing it
// (RULE15) monitoring channel 0 may remote-loop, only with its transmit clock running
// (RULE16) each line driver can be put in high impedance for protection switching
// (RULE17) master clock toggling: recovery on, transmit clock and loop pin pick mode
// (RULE18) master clock low: receiver down, no loopback, transmit clock sets shaping
// (RULE19) master clock high: data recovery only, loop pins select remote or analog
//
// The register addresses and the Wishbone slave port were left to the implementer.
module lultm_top
  import lultm_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 master_clk_i,
  input  lultm_sys_s  [NCH-1:0]     sys_tx_i,
  input  lultm_rx_s   [NCH-1:0]     cdr_rec_i,
  input  lultm_rxl_s  [NCH-1:0]     rx_line_i,
  input  wire logic   [NCH-1:0]     loss_of_signal_flag_i,
  input  lultm_lpin_s [NCH-1:0]     loop_select_pin_i,
  output lultm_rx_s   [NCH-1:0]     rx_o,
  output lultm_txl_s  [NCH-1:0]     tx_line_o,
  output logic        [NCH-1:0]     tx_line_oe_o,
  output lultm_rxl_s  [NCH-1:0]     cdr_line_o,
  output logic        [NCH-1:0]     rx_power_down_o,
  output logic        [NCH-1:0]     rx_data_only_o,
  output logic        [NCH-1:0]     pulse_shaping_o
);
  lultm_state_s s_q;
  lultm_state_s s_d;
  lultm_pin_e   mclk_st;
  logic         mclk_lvl;
  logic         mclk_rise;
  lultm_pin_e [NCH-1:0] system_tx_clock_in_st;
  logic [NCH-1:0] system_tx_clock_in_lvl;
  logic           system_tx_clock_in_tick;
  logic [CNT_W-1:0] system_tx_clock_in_limit;

  lultm_activity u_mclk (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .sig_i   (master_clk_i),
    .tick_i  (1'b1),
    .limit_i (STUCK_LIMIT),
    .state_o (mclk_st),
    .level_o (mclk_lvl),
    .rise_o  (mclk_rise)
  );

  // transmit clock is timed in master clocks; with no master clock fall back to clk_i
  assign system_tx_clock_in_tick  = (mclk_st == PIN_CLOCKED) ? mclk_rise : 1'b1;
  assign system_tx_clock_in_limit = (mclk_st == PIN_CLOCKED) ? SEND_ALL_ONES_LIMIT : STUCK_LIMIT;

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_system_tx_clock_in
      lultm_activity u_system_tx_clock_in (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .sig_i   (sys_tx_i[g].system_tx_clock_in),
        .tick_i  (system_tx_clock_in_tick),
        .limit_i (system_tx_clock_in_limit),
        .state_o (system_tx_clock_in_st[g]),
        .level_o (system_tx_clock_in_lvl[g]),
        .rise_o  ()
      );
    end
  endgenerate

  function automatic lultm_lpin_e lpin_of(input logic [1:0] p);
    if (!p[1]) begin
      return LPIN_OPEN;
    end
    return p[0] ? LPIN_HIGH : LPIN_LOW;
  endfunction

  // hardware-mode decoding of master clock, transmit clock and loop pin
  function automatic lultm_mode_s hw_decode(input lultm_pin_e m, input lultm_pin_e t,
                                            input lultm_lpin_e l);
    lultm_mode_s r;
    r = '{rx_pd: 1'b0, data_only: 1'b0, txm: TX_SHAPED, loop: LOOP_NONE};
    case (m)
      PIN_CLOCKED: begin
        case (t) // [RULE17]
          PIN_CLOCKED: r.loop = (l == LPIN_LOW) ? LOOP_REMOTE :
                                (l == LPIN_HIGH) ? LOOP_ANALOG : LOOP_NONE;
          PIN_LOW: r.txm = TX_PD;
          default: begin
            if (l == LPIN_LOW) begin
              r.loop = LOOP_REMOTE;
            end else begin
              r.txm = TX_ONES; // [RULE9]
            end
          end
        endcase
      end
      PIN_LOW: begin
        r.rx_pd = 1'b1; // [RULE18]
        r.txm = (t == PIN_CLOCKED) ? TX_SHAPED : (t == PIN_HIGH) ? TX_UNSHAPED : TX_PD;
      end
      default: begin
        r.data_only = 1'b1; // [RULE19]
        case (l)
          LPIN_LOW: begin
            r.loop = LOOP_REMOTE;
            r.txm = TX_UNSHAPED;
          end
          LPIN_HIGH: begin
            if (t == PIN_LOW) begin
              r.txm = TX_PD;
            end else begin
              r.loop = LOOP_ANALOG;
              r.txm = (t == PIN_CLOCKED) ? TX_SHAPED : TX_UNSHAPED;
            end
          end
          default: r.txm = (t == PIN_CLOCKED) ? TX_SHAPED :
                           (t == PIN_LOW) ? TX_PD : TX_UNSHAPED;
        endcase
      end
    endcase
    return r;
  endfunction

  always_comb begin
    lultm_mode_s md;
    logic [1:0]  src;
    logic [1:0]  rxl;
    md = '{rx_pd: 1'b0, data_only: 1'b0, txm: TX_SHAPED, loop: LOOP_NONE};
    src = 2'h0;
    rxl = 2'h0;
    s_d = s_q;
    // bus slave: one wait state, ack drops the cycle after it is given
    s_d.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
      s_d.ack = 1'b1;
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i) // [RULE1]
          ADR_MODE:  s_d.sw_mode = wb_dat_i[0];
          ADR_ANALOG_LOOP_CTL: s_d.analog_loop_ctl = wb_dat_i[NCH-1:0];
          ADR_DIGITAL_LOOP_CTL: s_d.digital_loop_ctl = wb_dat_i[NCH-1:0];
          ADR_REMOTE_LOOP_CTL: s_d.remote_loop_ctl = wb_dat_i[NCH-1:0];
          ADR_ONES:  s_d.ones = wb_dat_i[NCH-1:0];
          ADR_AUTO:  s_d.auto_all_ones_on_signal_loss = wb_dat_i[NCH-1:0];
          ADR_TRI:   s_d.drv_off = wb_dat_i[NCH-1:0];
          ADR_MON: begin
            s_d.mon_en = wb_dat_i[MON_EN_BIT];
            s_d.mon_ch = wb_dat_i[MON_CH_LSB +: 2];
            s_d.mon_out = wb_dat_i[MON_OUT_BIT];
          end
          default: ;
        endcase
      end
      s_d.rdat = 32'h0;
      case (wb_adr_i)
        ADR_MODE:  s_d.rdat[0] = s_q.sw_mode;
        ADR_ANALOG_LOOP_CTL: s_d.rdat[NCH-1:0] = s_q.analog_loop_ctl;
        ADR_DIGITAL_LOOP_CTL: s_d.rdat[NCH-1:0] = s_q.digital_loop_ctl;
        ADR_REMOTE_LOOP_CTL: s_d.rdat[NCH-1:0] = s_q.remote_loop_ctl;
        ADR_ONES:  s_d.rdat[NCH-1:0] = s_q.ones;
        ADR_AUTO:  s_d.rdat[NCH-1:0] = s_q.auto_all_ones_on_signal_loss;
        ADR_TRI:   s_d.rdat[NCH-1:0] = s_q.drv_off;
        ADR_MON:   s_d.rdat[3:0] = {s_q.mon_out, s_q.mon_ch, s_q.mon_en};
        ADR_STAT: begin
          s_d.rdat[1:0] = mclk_st;
          s_d.rdat[STAT_SYSTEM_TX_CLOCK_IN_LSB +: 2*NCH] = system_tx_clock_in_st;
          s_d.rdat[STAT_LOS_LSB +: NCH] = s_q.los2;
          s_d.rdat[STAT_ONES_LSB +: NCH] = s_q.ones_act;
        end
        ADR_LSTAT: s_d.rdat[2*NCH-1:0] = s_q.loop;
        default: ;
      endcase
    end
    // two-stage synchronisers; only the second stage feeds logic
    for (int c = 0; c < NCH; c++) begin
      s_d.sys1[c] = {sys_tx_i[c].system_tx_positive_rail, sys_tx_i[c].system_tx_negative_rail};
      s_d.cdr1[c] = cdr_rec_i[c];
      s_d.rxl1[c] = rx_line_i[c];
      s_d.lp1[c]  = loop_select_pin_i[c];
    end
    s_d.los1 = loss_of_signal_flag_i;
    s_d.sys2 = s_q.sys1;
    s_d.cdr2 = s_q.cdr1;
    s_d.rxl2 = s_q.rxl1;
    s_d.lp2  = s_q.lp1;
    s_d.los2 = s_q.los1;
    for (int c = 0; c < NCH; c++) begin
      if (!s_q.sw_mode) begin
        md = hw_decode(mclk_st, system_tx_clock_in_st[c], lpin_of(s_q.lp2[c]));
      end else begin
        md = '{rx_pd: 1'b0, data_only: 1'b0, txm: TX_SHAPED, loop: LOOP_NONE};
        md.rx_pd = (mclk_st == PIN_LOW);
        md.data_only = (mclk_st == PIN_HIGH);
        if (s_q.ones[c] || (s_q.auto_all_ones_on_signal_loss[c] && s_q.los2[c])) begin
          md.txm = TX_ONES; // [RULE10] [RULE11]
        end
        if (s_q.remote_loop_ctl[c]) begin
          md.loop = LOOP_REMOTE;
        end else if (s_q.analog_loop_ctl[c]) begin
          md.loop = LOOP_ANALOG;
        end else if (s_q.digital_loop_ctl[c] && md.txm != TX_ONES) begin
          md.loop = LOOP_DIGITAL; // [RULE13]
        end
      end
      if (md.txm == TX_ONES && mclk_st != PIN_CLOCKED) begin
        md.txm = TX_SHAPED; // [RULE12]
      end
      if (c == 0 && s_q.sw_mode && s_q.mon_en) begin
        // monitor channel keeps only a remote loop, and only with its own clock alive
        md.loop = (md.loop == LOOP_REMOTE && system_tx_clock_in_st[0] == PIN_CLOCKED) ?
                  LOOP_REMOTE : LOOP_NONE; // [RULE15]
      end
      src = (md.loop == LOOP_REMOTE) ? s_q.cdr2[c][1:0] : s_q.sys2[c]; // [RULE7] [RULE8]
      if (md.txm == TX_ONES) begin
        if (mclk_rise) begin
          s_d.phase[c] = ~s_q.phase[c];
        end
        src = {s_q.phase[c], ~s_q.phase[c]};
      end
      s_d.tx[c] = (md.txm == TX_PD) ? 2'h0 : src; // [RULE5]
      s_d.oe[c] = (md.txm != TX_PD) && !s_q.drv_off[c]; // [RULE16]
      s_d.shape[c] = (md.txm == TX_SHAPED) || (md.txm == TX_ONES);
      // analog loop replaces the external line at the receiver input
      rxl = (md.loop == LOOP_ANALOG) ? s_q.tx[c] : s_q.rxl2[c]; // [RULE2] [RULE3]
      if (c == 0 && s_q.sw_mode && s_q.mon_en) begin
        rxl = s_q.mon_out ? s_q.tx[s_q.mon_ch] : s_q.rxl2[s_q.mon_ch]; // [RULE14]
      end
      s_d.cdr_in[c] = rxl;
      if (md.loop == LOOP_DIGITAL) begin
        s_d.rx[c] = {system_tx_clock_in_lvl[c], s_q.sys2[c]}; // [RULE4] [RULE6]
      end else if (md.rx_pd) begin
        s_d.rx[c] = 3'h0;
      end else begin
        s_d.rx[c] = s_q.cdr2[c];
      end
      s_d.rxpd[c] = md.rx_pd;
      s_d.donly[c] = md.data_only;
      s_d.ones_act[c] = (md.txm == TX_ONES);
      s_d.loop[c] = md.loop;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign tx_line_oe_o = s_q.oe;
  assign rx_power_down_o = s_q.rxpd;
  assign rx_data_only_o = s_q.donly;
  assign pulse_shaping_o = s_q.shape;
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_out
      assign rx_o[g] = s_q.rx[g];
      assign tx_line_o[g] = s_q.tx[g];
      assign cdr_line_o[g] = s_q.cdr_in[g];
    end
  endgenerate

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wb_tri_wr_s;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && wb_adr_i == ADR_TRI;
  endsequence
  sequence hw_send_all_ones_s;
    !s_q.sw_mode && mclk_st == PIN_CLOCKED && system_tx_clock_in_st[1] == PIN_HIGH && s_q.lp2[1] == 2'b00;
  endsequence

  tri_write_a: assert property (wb_tri_wr_s ##1 wb_ack_o |=>
                                tx_line_oe_o[0] == 1'b0 || !$past(wb_dat_i[0], 2)) // [RULE16]
    else $error("driver not tristated after write");
  hw_send_all_ones_a: assert property (hw_send_all_ones_s |=> s_q.ones_act[1] && pulse_shaping_o[1]) // [RULE9]
    else $error("hardware all ones not entered");
  ones_mclk_a: assert property (|s_q.ones_act |-> $past(mclk_st) == PIN_CLOCKED) // [RULE12]
    else $error("all ones without master clock");
  digital_loop_ctl_ones_a: assert property (s_q.ones_act[2] |-> s_q.loop[2] != LOOP_DIGITAL) // [RULE13]
    else $error("digital loop with all ones");
  remote_path_a: assert property (s_q.loop[1] == LOOP_REMOTE && !s_q.ones_act[1] &&
                                  tx_line_oe_o[1] |-> tx_line_o[1] == $past(s_q.cdr2[1][1:0]))
    else $error("remote loop data wrong"); // [RULE7]
  digital_path_a: assert property (s_q.loop[2] == LOOP_DIGITAL |->
                                   rx_o[2] == {$past(system_tx_clock_in_lvl[2]), $past(s_q.sys2[2])})
    else $error("digital loop receive copy wrong"); // [RULE4]
  analog_path_a: assert property (s_q.loop[3] == LOOP_ANALOG |->
                                  cdr_line_o[3] == $past(tx_line_o[3])) // [RULE3]
    else $error("analog loop receiver input wrong");
  monitor_in_a: assert property (s_q.sw_mode && s_q.mon_en && s_q.mon_ch == 2'h2 &&
                                 !s_q.mon_out |=> cdr_line_o[0] == $past(s_q.rxl2[2]))
    else $error("monitor input wrong"); // [RULE14]
  ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not single cycle"); // [RULE1]
  mclk_low_a: assert property (mclk_st == PIN_LOW |=> rx_power_down_o == 4'hf &&
                               s_q.loop[0] != LOOP_ANALOG) // [RULE18]
    else $error("receiver not powered down");
endmodule

// [pkg/lultm_pkg.sv]
// lultm_pkg: constants, enums and carrier structs of the quad line-unit test-mode block.
// assumes a single 200 MHz clock domain and classic wishbone register access.
package lultm_pkg;
  localparam int unsigned NCH = 4;
  localparam int unsigned CLK_PERIOD_NS = 5;
  // master clock counts as stuck after this long without an edge
  localparam int unsigned MCLK_STUCK_NS = 1280;
  localparam int unsigned MCLK_STUCK_CYC = MCLK_STUCK_NS / CLK_PERIOD_NS;
  // transmit clock held high for more than this many master clock cycles
  localparam int unsigned SEND_ALL_ONES_HIGH_MCLK = 16;
  localparam int unsigned CNT_W = 9;
  localparam logic [CNT_W-1:0] STUCK_LIMIT = CNT_W'(MCLK_STUCK_CYC);
  localparam logic [CNT_W-1:0] SEND_ALL_ONES_LIMIT = CNT_W'(SEND_ALL_ONES_HIGH_MCLK);
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_ANALOG_LOOP_CTL = 8'h04;
  localparam logic [7:0] ADR_DIGITAL_LOOP_CTL = 8'h08;
  localparam logic [7:0] ADR_REMOTE_LOOP_CTL = 8'h0c;
  localparam logic [7:0] ADR_ONES = 8'h10;
  localparam logic [7:0] ADR_AUTO = 8'h14;
  localparam logic [7:0] ADR_TRI = 8'h18;
  localparam logic [7:0] ADR_MON = 8'h1c;
  localparam logic [7:0] ADR_STAT = 8'h20;
  localparam logic [7:0] ADR_LSTAT = 8'h24;
  localparam int unsigned MON_EN_BIT = 0;
  localparam int unsigned MON_CH_LSB = 1;
  localparam int unsigned MON_OUT_BIT = 3;
  localparam int unsigned STAT_SYSTEM_TX_CLOCK_IN_LSB = 2;
  localparam int unsigned STAT_LOS_LSB = 10;
  localparam int unsigned STAT_ONES_LSB = 14;
  localparam logic [3:0] CH_RESET = 4'h0;

  typedef enum logic [1:0] {
    PIN_LOW     = 2'b00,
    PIN_HIGH    = 2'b01,
    PIN_CLOCKED = 2'b10
  } lultm_pin_e;
  typedef enum logic [1:0] {
    LPIN_OPEN = 2'b00,
    LPIN_LOW  = 2'b01,
    LPIN_HIGH = 2'b10
  } lultm_lpin_e;
  typedef enum logic [1:0] {
    LOOP_NONE    = 2'b00,
    LOOP_REMOTE  = 2'b01,
    LOOP_ANALOG  = 2'b10,
    LOOP_DIGITAL = 2'b11
  } lultm_loop_e;
  typedef enum logic [1:0] {
    TX_PD       = 2'b00,
    TX_SHAPED   = 2'b01,
    TX_UNSHAPED = 2'b10,
    TX_ONES     = 2'b11
  } lultm_txm_e;

  typedef struct packed {
    logic system_tx_clock_in;
    logic system_tx_positive_rail;
    logic system_tx_negative_rail;
  } lultm_sys_s;
  typedef struct packed {
    logic rx_clock;
    logic recovered_positive_rail;
    logic recovered_negative_rail;
  } lultm_rx_s;
  typedef struct packed {
    logic tx_line_tip;
    logic tx_line_ring;
  } lultm_txl_s;
  typedef struct packed {
    logic rx_line_tip;
    logic rx_line_ring;
  } lultm_rxl_s;
  typedef struct packed {
    logic driven;
    logic level;
  } lultm_lpin_s;
  typedef struct packed {
    logic       rx_pd;
    logic       data_only;
    lultm_txm_e txm;
    lultm_loop_e loop;
  } lultm_mode_s;
  typedef struct packed {
    logic [2:0]     s;
    logic [CNT_W-1:0] cnt;
    lultm_pin_e     st;
  } lultm_act_s;
  typedef struct packed {
    logic                ack;
    logic [31:0]         rdat;
    logic                sw_mode;
    logic [NCH-1:0]      analog_loop_ctl;
    logic [NCH-1:0]      digital_loop_ctl;
    logic [NCH-1:0]      remote_loop_ctl;
    logic [NCH-1:0]      ones;
    logic [NCH-1:0]      auto_all_ones_on_signal_loss;
    logic [NCH-1:0]      drv_off;
    logic                mon_en;
    logic [1:0]          mon_ch;
    logic                mon_out;
    logic [NCH-1:0][1:0] sys1;
    logic [NCH-1:0][1:0] sys2;
    logic [NCH-1:0][2:0] cdr1;
    logic [NCH-1:0][2:0] cdr2;
    logic [NCH-1:0][1:0] rxl1;
    logic [NCH-1:0][1:0] rxl2;
    logic [NCH-1:0]      los1;
    logic [NCH-1:0]      los2;
    logic [NCH-1:0][1:0] lp1;
    logic [NCH-1:0][1:0] lp2;
    logic [NCH-1:0]      phase;
    logic [NCH-1:0][2:0] rx;
    logic [NCH-1:0][1:0] tx;
    logic [NCH-1:0]      oe;
    logic [NCH-1:0][1:0] cdr_in;
    logic [NCH-1:0]      rxpd;
    logic [NCH-1:0]      donly;
    logic [NCH-1:0]      shape;
    logic [NCH-1:0]      ones_act;
    lultm_loop_e [NCH-1:0] loop;
  } lultm_state_s;
endpackage

// [verilog/lultm_activity.sv]
// lultm_activity: synchronises one clock-like pin and classes it as low, high or clocked.
// assumes tick_i is a one-cycle enable on clk_i and limit_i is steady between ticks.
module lultm_activity
  import lultm_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             sig_i,
  input  wire logic             tick_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output lultm_pin_e            state_o,
  output logic                  level_o,
  output logic                  rise_o
);
  lultm_act_s s_q;
  lultm_act_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.s = {s_q.s[1:0], sig_i};
    if (s_q.s[1] != s_q.s[2]) begin
      s_d.cnt = '0;
      s_d.st = PIN_CLOCKED;
    end else if (tick_i) begin
      // saturate so a long static level never wraps back to clocked
      if (s_q.cnt <= limit_i) begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
      if (s_q.cnt >= limit_i) begin
        s_d.st = s_q.s[1] ? PIN_HIGH : PIN_LOW; // [RULE9]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{s: 3'h0, cnt: '0, st: PIN_LOW};
    end else begin
      s_q <= s_d;
    end
  end

  assign state_o = s_q.st;
  assign level_o = s_q.s[1];
  assign rise_o  = s_q.s[1] & ~s_q.s[2];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  edge_resets_a: assert property ((s_q.s[1] != s_q.s[2]) |=> state_o == PIN_CLOCKED) // [RULE9]
    else $error("edge did not mark pin clocked");
endmodule

// [dv/lultm_line_model.sv]
// lultm_line_model: far end of each line plus the external clock and data recovery stage.
// assumes it shares clk_i with the block; the bench sets the far-end symbols.
module lultm_line_model
  import lultm_pkg::*;
(
  input  wire logic             clk_i,
  input  lultm_rxl_s [NCH-1:0]  far_i,
  input  lultm_rxl_s [NCH-1:0]  cdr_line_i,
  output lultm_rx_s  [NCH-1:0]  cdr_rec_o,
  output lultm_rxl_s [NCH-1:0]  rx_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rclk_q = 1'b0;
  // recovery retimes each symbol by one cycle, so loop paths are one cycle longer
  always_ff @(posedge clk_i) begin
    rclk_q <= ~rclk_q;
    for (int c = 0; c < NCH; c++) begin
      cdr_rec_o[c] <= {rclk_q, cdr_line_i[c]};
    end
  end
  assign rx_line_o = far_i;
endmodule

// [dv/test_line_unit_loopback_test_modes.sv]
// test_line_unit_loopback_test_modes: directed loopback, all-ones, monitor and tristate runs.
// assumes lultm_top on a 200 MHz clock with the line model at its far side.
module test_line_unit_loopback_test_modes
  import lultm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  wb_cyc_i = 1'b0;
  logic                  wb_stb_i = 1'b0;
  logic                  wb_we_i = 1'b0;
  logic [7:0]            wb_adr_i = '0;
  logic [3:0]            wb_sel_i = '0;
  logic [31:0]           wb_dat_i = '0;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  logic                  master_clk_i = 1'b0;
  logic                  lk = 1'b0;
  logic                  mk = 1'b0;
  logic [1:0]            tmode = 2'h2;
  logic [1:0]            mmode = 2'h2;
  lultm_sys_s  [NCH-1:0] sys_tx_i = '0;
  lultm_rx_s   [NCH-1:0] cdr_rec_i;
  lultm_rx_s   [NCH-1:0] rx_o;
  lultm_rxl_s  [NCH-1:0] rx_line_i;
  lultm_rxl_s  [NCH-1:0] cdr_line_o;
  lultm_rxl_s  [NCH-1:0] far = {NCH{2'b01}};
  lultm_txl_s  [NCH-1:0] tx_line_o;
  lultm_lpin_s [NCH-1:0] loop_select_pin_i = '0;
  logic [NCH-1:0]        loss_of_signal_flag_i = '0;
  logic [NCH-1:0]        tx_line_oe_o;
  logic [NCH-1:0]        rx_power_down_o;
  logic [NCH-1:0]        rx_data_only_o;
  logic [NCH-1:0]        pulse_shaping_o;
  int                    fail_count = 0;
  int                    num_checks = 0;

  always #2.5 clk_i = ~clk_i;
  always #32 lk = ~lk;
  always #40 mk = ~mk;
  // mode[1] runs the clock, else it holds level mode[0]; rails stay steady (pos 1, neg 0)
  always @(posedge clk_i) begin
    master_clk_i <= mmode[1] ? mk : mmode[0];
    for (int c = 0; c < NCH; c++) begin
      sys_tx_i[c] <= {(tmode[1] ? lk : tmode[0]), 2'b10};
    end
  end

  lultm_top i_lultm_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .master_clk_i, .sys_tx_i, .cdr_rec_i,
    .rx_line_i, .loss_of_signal_flag_i, .loop_select_pin_i, .rx_o, .tx_line_o,
    .tx_line_oe_o, .cdr_line_o, .rx_power_down_o, .rx_data_only_o, .pulse_shaping_o);
  lultm_line_model i_lultm_line_model (.clk_i, .far_i(far), .cdr_line_i(cdr_line_o),
    .cdr_rec_o(cdr_rec_i), .rx_line_o(rx_line_i));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("BAD %0t no bus answer", $time);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, '0, q);
    check(q, e);
  endtask

  // polls status until the masked field matches; a spent bound ends the run
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    int n;
    for (n = 0; n < 400; n++) begin
      wb(1'b0, ADR_STAT, '0, q);
      if ((q & m) === v) break;
    end
    check(q & m, v);
    if (n == 400) end_of_test();
  endtask

  // three sync and register stages plus the recovery retime
  task automatic settle();
    repeat (12) @(posedge clk_i);
  endtask

  task automatic t_regs();
    rd(ADR_ANALOG_LOOP_CTL, 32'h0);
    wr(ADR_ANALOG_LOOP_CTL, 32'hffff_fff5);
    rd(ADR_ANALOG_LOOP_CTL, 32'h5);
    rd(ADR_LSTAT, 32'h0);
    wr(ADR_LSTAT, 32'hff);
    rd(ADR_LSTAT, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h80, 32'h0);
    wr(ADR_ANALOG_LOOP_CTL, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_hw();
    loop_select_pin_i[1] <= 2'b10;
    loop_select_pin_i[2] <= 2'b11;
    settle();
    rd(ADR_LSTAT, 32'h24);
    check(32'(tx_line_o[1]), 32'h1);
    check(32'(cdr_line_o[2]), 32'h2);
    check(32'(rx_o[2][1:0]), 32'h2);
    mmode <= 2'h1;
    wait_stat(32'h3, 32'h1);
    settle();
    rd(ADR_LSTAT, 32'h24);
    check(32'(pulse_shaping_o[2:1]), 32'h2);
    check(32'(rx_data_only_o), 32'hf);
    mmode <= 2'h0;
    wait_stat(32'h3, 32'h0);
    settle();
    rd(ADR_LSTAT, 32'h0);
    check(32'(rx_power_down_o), 32'hf);
    check(32'(pulse_shaping_o), 32'hf);
    tmode <= 2'h1;
    wait_stat(32'h3c3ff, 32'h154);
    settle();
    check(32'(pulse_shaping_o), 32'h0);
    mmode <= 2'h2;
    tmode <= 2'h2;
    loop_select_pin_i <= '0;
    wait_stat(32'h3ff, 32'h2aa);
    $display("t_hw done");
  endtask

  task automatic t_hw_ones();
    tmode <= 2'h1;
    // about twelve master clocks: too early for all ones
    repeat (190) @(posedge clk_i);
    rd(ADR_STAT, 32'h2aa);
    wait_stat(32'h3c000, 32'h3c000);
    check(32'(^tx_line_o[0]), 32'h1);
    tmode <= 2'h2;
    wait_stat(32'h3c3ff, 32'h2aa);
    $display("t_hw_ones done");
  endtask

  task automatic t_sw();
    loop_select_pin_i[1] <= 2'b10;
    wr(ADR_MODE, 32'h1);
    wr(ADR_DIGITAL_LOOP_CTL, 32'h8);
    settle();
    rd(ADR_LSTAT, 32'hc0);
    check(32'(rx_o[3][1:0]), 32'h2);
    check(32'(tx_line_o[3]), 32'h2);
    wr(ADR_ONES, 32'h8);
    wait_stat(32'h3c000, 32'h20000);
    rd(ADR_LSTAT, 32'h0);
    check(32'(^tx_line_o[3]), 32'h1);
    mmode <= 2'h1;
    wait_stat(32'h3c003, 32'h1);
    mmode <= 2'h2;
    wait_stat(32'h3, 32'h2);
    wr(ADR_ONES, 32'h0);
    wr(ADR_DIGITAL_LOOP_CTL, 32'h0);
    loop_select_pin_i <= '0;
    $display("t_sw done");
  endtask

  task automatic t_auto();
    wr(ADR_AUTO, 32'h1);
    loss_of_signal_flag_i <= 4'h1;
    wait_stat(32'h3c000, 32'h4000);
    loss_of_signal_flag_i <= 4'h0;
    wait_stat(32'h3c000, 32'h0);
    wr(ADR_AUTO, 32'h0);
    $display("t_auto done");
  endtask

  task automatic t_mon();
    far[2] <= 2'b10;
    wr(ADR_MON, 32'h5);
    settle();
    check(32'(cdr_line_o[0]), 32'h2);
    check(32'(cdr_line_o[2]), 32'h2);
    check(32'(rx_o[0][1:0]), 32'h2);
    wr(ADR_REMOTE_LOOP_CTL, 32'h1);
    settle();
    check(32'(tx_line_o[0]), 32'h2);
    wr(ADR_MON, 32'h0);
    wr(ADR_REMOTE_LOOP_CTL, 32'h0);
    far[2] <= 2'b01;
    $display("t_mon done");
  endtask

  task automatic t_tri();
    wr(ADR_TRI, 32'h3);
    settle();
    check(32'(tx_line_oe_o), 32'hc);
    wr(ADR_TRI, 32'h0);
    settle();
    check(32'(tx_line_oe_o), 32'hf);
    $display("t_tri done");
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_stat(32'h3ff, 32'h2aa);
    t_regs();
    t_hw();
    t_hw_ones();
    t_sw();
    t_auto();
    t_mon();
    t_tri();
    end_of_test();
  end
endmodule
